// >>> inc/pfss_defs.svh
// Purpose: Shared constants of the position frame link, both ends.
// Assumes: 200 MHz aclk on both ends.
// Notes: Times are kept in their own unit; the idle and time-out cycle counts derive from them, the half-period counts are literals.
`ifndef PFSS_DEFS_SVH
`define PFSS_DEFS_SVH

`define PFSS_CLK_PERIOD_PS 5000
`define PFSS_FRAME_BITS 6'd48
`define PFSS_POS_BITS 22
`define PFSS_RES_BITS 22
`define PFSS_CRC_POLY 7'h5b
`define PFSS_CRC_INIT 7'h00

// Frame bit positions.
`define PFSS_BIT_ZPD 32
`define PFSS_BIT_VALID 31
`define PFSS_BIT_SYNC 30
`define PFSS_BIT_POS_HI 29
`define PFSS_BIT_POS_LO 8
`define PFSS_BIT_STALE 7

// Idle time after which the device drops a frame (least time, rounds up).
`define PFSS_T_IDLE_NS 10000
`define PFSS_IDLE_CYC \
  ((`PFSS_T_IDLE_NS * 1000 + `PFSS_CLK_PERIOD_PS - 1) / `PFSS_CLK_PERIOD_PS)
// Measurement time-out, middle of its window (rounds down).
`define PFSS_T_MTO_NS 140000
`define PFSS_MTO_CYC ((`PFSS_T_MTO_NS * 1000) / `PFSS_CLK_PERIOD_PS)
// Serial clock half periods: 5 MHz fastest, 100 kHz slowest.
`define PFSS_T_HALF_MIN_NS 100
`define PFSS_T_HALF_MAX_NS 5000
`define PFSS_HALF_MIN_CYC 10'd20
`define PFSS_HALF_MAX_CYC 10'd1000
`define PFSS_DIV_RST 10'h014

// Controller register byte offsets.
`define PFSS_REG_CTRL 8'h00
`define PFSS_REG_STATUS 8'h04
`define PFSS_REG_POS 8'h08
`define PFSS_REG_FRAME_HI 8'h0c
`define PFSS_REG_FRAME_LO 8'h10
`define PFSS_REG_IRQ_STAT 8'h14
`define PFSS_REG_IRQ_MASK 8'h18
`define PFSS_REG_CLKDIV 8'h1c
`define PFSS_IRQ_DONE 0
`define PFSS_IRQ_CRC_ERR 1
`define PFSS_MASK_RST 2'h0

`endif

// >>> inc/pfss_pkg.sv
// Purpose: Types and the frame checksum shared by both ends.
// Assumes: Nothing beyond the constants header.
// Notes: The checksum runs over a 32-bit word, most significant bit first.
package pfss_pkg;

  typedef enum logic [1:0] {
    PFSS_IDLE = 2'b00,
    PFSS_LOW = 2'b01,
    PFSS_HIGH = 2'b10
  } pfss_state_t;

  typedef logic [47:0] pfss_frame_t;

  function automatic logic [6:0] pfss_crc7(input logic [31:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 31; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h5b;
      end
    end
    return c;
  endfunction

endpackage

// >>> inc/pfss_link_if.sv
// Purpose: Serial link between position device and controller.
// Assumes: Both ends run on their own aclk; the link is asynchronous to them.
// Notes: Serial clock rests high between frames.
`timescale 1ns/1ps
interface pfss_link_if;
  logic sclk;
  logic sdo;
  modport dev (input sclk, output sdo);
  modport ctl (output sclk, input sdo);
endinterface // pfss_link_if

// >>> verilog/pfss_dev.sv
// Purpose: Position device end: shifts a 48-bit frame to the serial master.
// Assumes: aclk at 200 MHz; measurement core on aclk.
// Notes: The serial clock is sampled, so it must stay well below aclk/4.
//
// Behaviour
// R1 - Every frame is six bytes, 48 bits.
// R2 - Serial clock idles high between transfers.
// R3 - Data changes on rise, sampled on fall.
// R4 - Host clock between 100 kHz and 5 MHz.
// R5 - Bits 47 to 33 always zero.
// R6 - Bit 32 flags factory zero point.
// R7 - Bit 31 flags valid position.
// R8 - Bit 30 flags frame-triggered measurement.
// R9 - Bits 29..8 position, unused MSBs zero.
// R10 - Host ignores position when not valid.
// R11 - Bit 7 flags already sent position.
// R12 - Bits 6..0 CRC poly 5b, init 0.
// R13 - CRC over bits 7..32 in 32-bit word.
// R14 - Frame start triggers measurement unless busy.
// R15 - Self trigger after measurement time-out.
// R16 - Idle serial clock resets frame logic.
// R17 - Shift out most significant bit first.
// R18 - Frame latched before first bit, held.
`timescale 1ns/1ps
`include "pfss_defs.svh"
module pfss_dev #(
  parameter int unsigned MTO_CYCLES = `PFSS_MTO_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  pfss_link_if.dev link,
  output logic meas_start,
  input wire logic meas_done,
  input wire logic [21:0] meas_position,
  input wire logic meas_valid,
  input wire logic zero_default,
  output logic frame_active,
  output logic frame_abort
);

  localparam logic [11:0] IDLE_CYC = 12'(`PFSS_IDLE_CYC);

  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  logic sclk_rise;
  logic sclk_fall;
  logic [11:0] idle_cnt_r;
  logic idle_done;
  logic active_r;
  logic [5:0] fall_cnt_r;
  logic start_frame;
  logic [46:0] shift_r;
  logic sdo_r;
  logic abort_r;
  logic busy_r;
  logic trig_sync_r;
  logic [31:0] mto_cnt_r;
  logic trig_frame;
  logic trig_timeout;
  logic meas_start_r;
  logic [21:0] pos_r;
  logic valid_r;
  logic sync_r;
  logic zpd_r;
  logic stale_r;
  logic [21:0] res_mask;
  logic [25:0] payload;
  pfss_pkg::pfss_frame_t frame_word;

  // The first stage feeds only the second; edges are found one stage later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
    end else begin
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
    end
  end

  assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
  assign sclk_fall = ~sclk_s2_r & sclk_s3_r; // R3

  // Any edge restarts the idle count; it saturates at the idle limit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt_r <= 12'h000;
    end else if (sclk_rise || sclk_fall) begin
      idle_cnt_r <= 12'h000;
    end else if (idle_cnt_r != IDLE_CYC) begin
      idle_cnt_r <= idle_cnt_r + 12'h001;
    end
  end

  // An edge in the last idle cycle still belongs to the link, so it is not lost.
  assign idle_done = (idle_cnt_r == IDLE_CYC - 12'h001) & ~sclk_rise & ~sclk_fall; // R16
  assign start_frame = sclk_fall & ~active_r;

  // Frame tracking: one fall opens a frame, the 48th closes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_r <= 1'b0;
      fall_cnt_r <= 6'h00;
    end else if (idle_done) begin
      active_r <= 1'b0; // R16
      fall_cnt_r <= 6'h00; // R16
    end else if (start_frame) begin
      active_r <= 1'b1;
      fall_cnt_r <= 6'h01;
    end else if (sclk_fall) begin
      fall_cnt_r <= fall_cnt_r + 6'h01;
      if (fall_cnt_r == `PFSS_FRAME_BITS - 6'h01) begin
        active_r <= 1'b0; // R1
      end
    end
  end

  // A frame cut short by an idle clock is reported for one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= idle_done & active_r;
    end
  end

  // Unused high position bits are forced to zero.
  genvar gi;
  generate
    for (gi = 0; gi < `PFSS_POS_BITS; gi++) begin : g_res
      assign res_mask[gi] = (gi < `PFSS_RES_BITS); // R9
    end
  endgenerate

  assign payload = {zpd_r, valid_r, sync_r, pos_r, stale_r}; // R6 R7 R8 R9 R11
  assign frame_word = {15'h0000, payload,
                       pfss_pkg::pfss_crc7({6'h00, payload})}; // R5 R12 R13

  // Bits 46..0 of the frame are captured at the first fall, so flags cannot move
  // under it while it is being shifted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= 47'h0;
    end else if (start_frame) begin
      shift_r <= frame_word[46:0]; // R18
    end else if (sclk_rise && active_r) begin
      shift_r <= {shift_r[45:0], 1'b0}; // R17
    end
  end

  // Bit 47 is always zero, so a resting low output already presents it
  // before the host's first fall.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdo_r <= 1'b0;
    end else if (!active_r || idle_done) begin
      sdo_r <= 1'b0; // R5
    end else if (sclk_rise) begin
      sdo_r <= shift_r[46]; // R3 R17
    end
  end

  assign trig_frame = start_frame & ~busy_r; // R14
  assign trig_timeout = ~busy_r & ~start_frame & (mto_cnt_r >= MTO_CYCLES - 1); // R15

  // Time since the last trigger of either kind.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mto_cnt_r <= 32'h0;
    end else if (trig_frame || trig_timeout) begin
      mto_cnt_r <= 32'h0;
    end else if (mto_cnt_r < MTO_CYCLES) begin
      mto_cnt_r <= mto_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      trig_sync_r <= 1'b0;
      meas_start_r <= 1'b0;
    end else begin
      meas_start_r <= trig_frame | trig_timeout;
      if (trig_frame || trig_timeout) begin
        busy_r <= 1'b1;
        trig_sync_r <= trig_frame; // R8
      end else if (meas_done) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Latest completed measurement. A completion in the cycle a frame opens
  // wins, so the fresh result is never marked stale before it is sent.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= 22'h000000;
      valid_r <= 1'b0;
      sync_r <= 1'b0;
      zpd_r <= 1'b0;
      stale_r <= 1'b0;
    end else if (meas_done) begin
      pos_r <= meas_position & res_mask; // R9
      valid_r <= meas_valid; // R7
      sync_r <= trig_sync_r; // R8
      zpd_r <= zero_default; // R6
      stale_r <= 1'b0; // R11
    end else if (start_frame) begin
      stale_r <= 1'b1; // R11
    end
  end

  assign link.sdo = sdo_r;
  assign meas_start = meas_start_r;
  assign frame_active = active_r;
  assign frame_abort = abort_r;

endmodule // pfss_dev

// >>> verilog/pfss_ctl.sv
// Purpose: Serial master that reads position frames, with AXI4-Lite registers.
// Assumes: aclk at 200 MHz; one outstanding read and write on the bus.
// Notes: Serial clock comes from a divider of aclk and rests high.
`timescale 1ns/1ps
`include "pfss_defs.svh"
module pfss_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  pfss_link_if.ctl link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  pfss_pkg::pfss_state_t state_r;
  logic sclk_r;
  logic sdo_s1_r;
  logic sdo_s2_r;
  logic [9:0] half_r;
  logic [9:0] div_cnt_r;
  logic [5:0] bit_cnt_r;
  logic [47:0] sh_r;
  logic [47:0] frame_r;
  logic crc_ok_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic irq_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_nxt;
  logic w_nxt;
  logic rvalid_nxt;
  logic wr_fire;
  logic rd_fire;
  logic go;
  logic half_end;
  logic frame_done;
  logic crc_good;
  logic [31:0] wmask;
  logic [31:0] wmerged;
  logic [31:0] rd_val;
  logic rd_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdo_s1_r <= 1'b0;
      sdo_s2_r <= 1'b0;
    end else begin
      sdo_s1_r <= link.sdo;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  // Write path: address and data are held independently, answered together.
  assign aw_nxt = aw_hold_r ? ~(bvalid_r & s_axi_bready) : (s_axi_awvalid & awready_r);
  assign w_nxt = w_hold_r ? ~(bvalid_r & s_axi_bready) : (s_axi_wvalid & wready_r);
  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  assign go = wr_fire & (awaddr_r == `PFSS_REG_CTRL) & wstrb_r[0] & wdata_r[0];

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wmask[gb*8 +: 8] = {8{wstrb_r[gb]}};
    end
  endgenerate
  assign wmerged = wdata_r & wmask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      aw_hold_r <= aw_nxt;
      w_hold_r <= w_nxt;
      awready_r <= ~aw_nxt;
      wready_r <= ~w_nxt;
      if (s_axi_awvalid && awready_r) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r[7:5] != 3'h0 || awaddr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Writable registers. The divider is clamped to the legal clock range.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_r <= `PFSS_DIV_RST;
      mask_r <= `PFSS_MASK_RST;
    end else if (wr_fire) begin
      if (awaddr_r == `PFSS_REG_IRQ_MASK && wstrb_r[0]) begin
        mask_r <= wmerged[1:0];
      end
      if (awaddr_r == `PFSS_REG_CLKDIV && wstrb_r[1:0] == 2'h3) begin
        if (wmerged[9:0] < `PFSS_HALF_MIN_CYC || wmerged[31:10] != 22'h0) begin
          half_r <= (wmerged[31:10] != 22'h0) ? `PFSS_HALF_MAX_CYC : `PFSS_HALF_MIN_CYC; // R4
        end else if (wmerged[9:0] > `PFSS_HALF_MAX_CYC) begin
          half_r <= `PFSS_HALF_MAX_CYC; // R4
        end else begin
          half_r <= wmerged[9:0];
        end
      end
    end
  end

  // Serial engine. Each fall samples the bit the device set up on the
  // previous rise; the first bit is the always-zero top bit.
  // A divider lowered mid-frame ends the half at once instead of wrapping.
  assign half_end = (div_cnt_r >= half_r - 10'h001); // R4
  assign frame_done = (state_r == pfss_pkg::PFSS_HIGH) & half_end
                      & (bit_cnt_r == `PFSS_FRAME_BITS);
  assign crc_good = (pfss_pkg::pfss_crc7({6'h00, sh_r[32:7]}) == sh_r[6:0]); // R13

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= pfss_pkg::PFSS_IDLE;
      sclk_r <= 1'b1;
      div_cnt_r <= 10'h000;
      bit_cnt_r <= 6'h00;
      sh_r <= 48'h0;
    end else begin
      unique case (state_r)
        pfss_pkg::PFSS_IDLE: begin
          sclk_r <= 1'b1; // R2
          if (go) begin
            state_r <= pfss_pkg::PFSS_LOW;
            sclk_r <= 1'b0;
            sh_r <= {sh_r[46:0], sdo_s2_r}; // R3
            bit_cnt_r <= 6'h01;
            div_cnt_r <= 10'h000;
          end
        end
        pfss_pkg::PFSS_LOW: begin
          div_cnt_r <= half_end ? 10'h000 : div_cnt_r + 10'h001;
          if (half_end) begin
            state_r <= pfss_pkg::PFSS_HIGH;
            sclk_r <= 1'b1;
          end
        end
        pfss_pkg::PFSS_HIGH: begin
          div_cnt_r <= half_end ? 10'h000 : div_cnt_r + 10'h001;
          if (frame_done) begin
            state_r <= pfss_pkg::PFSS_IDLE; // R1
          end else if (half_end) begin
            state_r <= pfss_pkg::PFSS_LOW;
            sclk_r <= 1'b0;
            sh_r <= {sh_r[46:0], sdo_s2_r}; // R3
            bit_cnt_r <= bit_cnt_r + 6'h01;
          end
        end
        default: begin
          state_r <= pfss_pkg::PFSS_IDLE;
          sclk_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_r <= 48'h0;
      crc_ok_r <= 1'b0;
    end else if (frame_done) begin
      frame_r <= sh_r;
      crc_ok_r <= crc_good; // R12
    end
  end

  // Read path and read-to-clear status; a new event beats the clear.
  assign rd_fire = s_axi_arvalid & arready_r;
  assign rvalid_nxt = rvalid_r ? ~s_axi_rready : rd_fire;

  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `PFSS_REG_CTRL: rd_val = 32'h0;
      `PFSS_REG_STATUS: rd_val = {26'h0, frame_r[`PFSS_BIT_ZPD], frame_r[`PFSS_BIT_STALE],
                                  frame_r[`PFSS_BIT_SYNC], frame_r[`PFSS_BIT_VALID],
                                  crc_ok_r, state_r != pfss_pkg::PFSS_IDLE};
      // Software must ignore the position while the valid bit is clear.
      `PFSS_REG_POS: rd_val = {10'h0, frame_r[`PFSS_BIT_POS_HI:`PFSS_BIT_POS_LO]}; // R10
      `PFSS_REG_FRAME_HI: rd_val = {16'h0, frame_r[47:32]};
      `PFSS_REG_FRAME_LO: rd_val = frame_r[31:0];
      `PFSS_REG_IRQ_STAT: rd_val = {30'h0, stat_r};
      `PFSS_REG_IRQ_MASK: rd_val = {30'h0, mask_r};
      `PFSS_REG_CLKDIV: rd_val = {22'h0, half_r};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else begin
      rvalid_r <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (rd_fire) begin
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? 2'h0 : 2'h2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      if (rd_fire && s_axi_araddr == `PFSS_REG_IRQ_STAT) begin
        stat_r <= {frame_done & ~crc_good, frame_done};
      end else begin
        stat_r <= stat_r | {frame_done & ~crc_good, frame_done};
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  assign link.sclk = sclk_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = irq_r;

endmodule // pfss_ctl

// >>> testbench/pfss_link_properties.sv
// Purpose: Concurrent checks on the serial link between the two ends.
// Assumes: One aclk for both ends; synchronous active-low reset.
// Notes: Watches the first link only; the second link is judged by the bench.
`timescale 1ns/1ps
module pfss_link_properties #(
  parameter int unsigned MTO_CYCLES = 3000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic frame_active,
  input wire logic frame_abort,
  input wire logic meas_start,
  input wire logic meas_done
);
  localparam int unsigned IDLE_CYC = 2000;
  logic [15:0] low_cnt_r;
  logic [15:0] idle_cnt_r;
  logic [15:0] mto_cnt_r;
  logic [5:0] fall_cnt_r;
  logic busy_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Idle and time-out counters saturate so a long quiet spell cannot wrap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r <= 16'h0000;
      idle_cnt_r <= 16'h0000;
      mto_cnt_r <= 16'h0000;
      fall_cnt_r <= 6'h00;
      busy_r <= 1'b0;
    end else begin
      low_cnt_r <= sclk ? 16'h0000 : low_cnt_r + 16'h0001;
      idle_cnt_r <= $changed(sclk) ? 16'h0000 : idle_cnt_r + {15'h0000, idle_cnt_r != 16'hffff};
      mto_cnt_r <= meas_start ? 16'h0000 : mto_cnt_r + {15'h0000, mto_cnt_r != 16'hffff};
      busy_r <= meas_start | (busy_r & ~meas_done);
      fall_cnt_r <= $fell(frame_active) ? {5'h00, $fell(sclk)} : fall_cnt_r + {5'h00, $fell(sclk)};
    end
  end

  sequence s_frame_end;
    $fell(frame_active) ##0 !frame_abort;
  endsequence

  reset_idle_a: assert property ($rose(aresetn) |-> sclk && !sdo)
    else $error("link not idle after reset");
  half_period_a: assert property ($rose(sclk) |-> low_cnt_r >= 16'h0014 && low_cnt_r <= 16'h03e8)
    else $error("serial clock low half out of range");
  data_rise_a: assert property ($changed(sdo) && frame_active && $past(frame_active) |-> sclk)
    else $error("data changed while serial clock low");
  frame_len_a: assert property (s_frame_end |-> fall_cnt_r == 6'h30)
    else $error("frame did not hold 48 bits");
  start_meas_a: assert property ($rose(frame_active) && !busy_r |-> ##[0:4] meas_start)
    else $error("frame start did not trigger measurement");
  no_retrig_a: assert property (busy_r |-> !meas_start)
    else $error("measurement retriggered while busy");
  timeout_meas_a: assert property (mto_cnt_r > MTO_CYCLES + 4 |-> busy_r || $past(busy_r, 4))
    else $error("no measurement after time-out");
  abort_late_a: assert property (frame_abort |-> idle_cnt_r >= IDLE_CYC)
    else $error("frame dropped before idle time");
  idle_reset_a: assert property (idle_cnt_r > IDLE_CYC + 8 |-> !frame_active)
    else $error("frame kept after idle time");
endmodule // pfss_link_properties

// >>> testbench/tb_top.sv
// Purpose: Runs controller and device against each other over the serial link.
// Assumes: 200 MHz aclk; the bench plays the measurement core of the device.
// Notes: A second device on a bench-driven link covers the idle drop.
`timescale 1ns/1ps
`include "pfss_defs.svh"
module tb_top;
  localparam int unsigned MTO = 3000;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic meas_start, meas_done, meas_valid, zero_default, frame_active, frame_abort;
  logic active_b, abort_b, cur_v, cur_zd, pend;
  logic [21:0] meas_position, cur_pos;
  logic [47:0] wire_sh;
  int meas_lat, lat_cnt, n_done, cyc, err_total, cmp_count;
  pfss_link_if link();
  pfss_link_if link_b();

  pfss_dev #(.MTO_CYCLES(MTO)) i_pfss_dev (.aclk(aclk), .aresetn(aresetn), .link(link),
    .meas_start(meas_start), .meas_done(meas_done), .meas_position(meas_position),
    .meas_valid(meas_valid), .zero_default(zero_default), .frame_active(frame_active),
    .frame_abort(frame_abort));
  pfss_dev #(.MTO_CYCLES(MTO)) i_pfss_dev_b (.aclk(aclk), .aresetn(aresetn), .link(link_b),
    .meas_start(), .meas_done(meas_done), .meas_position(meas_position),
    .meas_valid(meas_valid), .zero_default(zero_default), .frame_active(active_b),
    .frame_abort(abort_b));
  pfss_ctl i_pfss_ctl (.aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  pfss_link_properties #(.MTO_CYCLES(MTO)) i_pfss_link_properties (.aclk(aclk),
    .aresetn(aresetn), .sclk(link.sclk), .sdo(link.sdo), .frame_active(frame_active),
    .frame_abort(frame_abort), .meas_start(meas_start), .meas_done(meas_done));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Measurement core: answers each trigger after meas_lat cycles with cur_* values.
  always @(posedge aclk) begin
    meas_done <= 1'b0;
    if (meas_start === 1'b1) begin
      pend <= 1'b1;
      lat_cnt <= 0;
    end else if (pend && lat_cnt >= meas_lat) begin
      pend <= 1'b0;
      meas_done <= 1'b1;
      meas_position <= cur_pos;
      meas_valid <= cur_v;
      zero_default <= cur_zd;
      n_done <= n_done + 1;
    end else begin
      lat_cnt <= lat_cnt + 1;
    end
  end

  always @(negedge link.sclk) begin
    wire_sh <= {wire_sh[46:0], link.sdo};
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      summarize();
    end
  end

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected frame built independently of the design's checksum function.
  function automatic logic [47:0] mk(logic zd, logic v, logic s, logic [21:0] p, logic st);
    logic [31:0] w;
    logic [6:0] c;
    w = {6'h00, zd, v, s, p, st};
    c = 7'h00;
    for (int i = 31; i >= 0; i--) begin
      c = (w[i] ^ c[6]) ? ({c[5:0], 1'b0} ^ 7'h5b) : {c[5:0], 1'b0};
    end
    return {15'h0000, w[25:0], c};
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && (awready === 1'b1);
      w_t = wvalid && (wready === 1'b1);
      b_t = bready && (bvalid === 1'b1);
      resp = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid && (arready === 1'b1);
      r_t = rready && (rvalid === 1'b1);
      dat = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
  endtask

  task automatic irq_after(input logic [31:0] mask, input logic exp);
    axi_wr(`PFSS_REG_IRQ_MASK, mask, r);
    repeat (3) @(negedge aclk);
    chk("irq", irq, exp);
  endtask

  task automatic run_frame(input logic [47:0] exp);
    logic [31:0] hi;
    axi_wr(`PFSS_REG_CTRL, 32'h0000_0001, r);
    while (irq !== 1'b1) @(negedge aclk);
    axi_rd(`PFSS_REG_FRAME_HI, hi, r);
    axi_rd(`PFSS_REG_FRAME_LO, d, r);
    chk("frame", {hi[15:0], d}, exp);
    chk("wire", wire_sh, exp);
    axi_rd(`PFSS_REG_STATUS, d, r);
    chk("status", d[5:0], {exp[32], exp[7], exp[30], exp[31], 2'b10});
    axi_rd(`PFSS_REG_POS, d, r);
    chk("pos", d, {26'h0, exp[29:8]});
    irq_after(32'h0, 1'b0);
    irq_after(32'h1, 1'b1);
    axi_rd(`PFSS_REG_IRQ_STAT, d, r);
    chk("irq_stat", d[1:0], 2'b01);
    repeat (3) @(negedge aclk);
    chk("irq_clr", irq, 1'b0);
  endtask

  task automatic t_regs;
    axi_rd(`PFSS_REG_CLKDIV, d, r);
    chk("clkdiv_rst", d, 32'h14);
    axi_rd(`PFSS_REG_IRQ_MASK, d, r);
    chk("mask_rst", d, 32'h0);
    axi_rd(8'h20, d, r);
    chk("rd_unmapped", r, 2'b10);
    axi_wr(8'h22, 32'h1, r);
    chk("wr_unaligned", r, 2'b10);
    axi_wr(`PFSS_REG_CLKDIV, 32'h5, r);
    axi_rd(`PFSS_REG_CLKDIV, d, r);
    chk("clkdiv_clamp", d, 32'h14);
    irq_after(32'h1, 1'b0);
  endtask

  // Time-out data first, then frame-triggered data, then a frame while busy.
  task automatic t_frames;
    while (n_done < 1) @(negedge aclk);
    cur_pos = 22'h3fffff;
    cur_v = 1'b0;
    cur_zd = 1'b0;
    run_frame(mk(1'b1, 1'b1, 1'b0, 22'h2abcde, 1'b0));
    while (n_done < 2) @(negedge aclk);
    meas_lat = 4000;
    run_frame(mk(1'b0, 1'b0, 1'b1, 22'h3fffff, 1'b0));
    axi_wr(`PFSS_REG_CLKDIV, 32'h1e, r);
    run_frame(mk(1'b0, 1'b0, 1'b1, 22'h3fffff, 1'b1));
    meas_lat = 50;
  endtask

  // Second device: one bit, then silence; it must drop and restart the frame.
  task automatic t_abort;
    int n;
    @(posedge aclk);
    link_b.sclk <= 1'b0;
    repeat (20) @(posedge aclk);
    link_b.sclk <= 1'b1;
    repeat (20) @(negedge aclk);
    chk("b_active", active_b, 1'b1);
    n = 0;
    while (abort_b !== 1'b1 && n < 2100) begin
      @(negedge aclk);
      n++;
    end
    chk("b_abort_time", (n >= 1975 && n <= 1995), 1'b1);
    @(negedge aclk);
    chk("b_dropped", active_b, 1'b0);
    @(posedge aclk);
    link_b.sclk <= 1'b0;
    repeat (8) @(negedge aclk);
    chk("b_restart", {active_b, link_b.sdo}, 2'b10);
    @(posedge aclk);
    link_b.sclk <= 1'b1;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pend, meas_done} = 8'h00;
    {meas_valid, zero_default, meas_position, wire_sh} = 72'h0;
    {awaddr, araddr, wdata} = 48'h0;
    link_b.sclk = 1'b1;
    cur_pos = 22'h2abcde;
    cur_v = 1'b1;
    cur_zd = 1'b1;
    {meas_lat, lat_cnt, n_done, cyc, err_total, cmp_count} = {32'd50, 160'h0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_frames();
    t_abort();
    summarize();
  end
endmodule // tb_top
